// ==== its_pkg.sv ====
// Purpose: Shared constants and types for the slave-transmit clock-stretch block
// Assumes: Included by every design file through its_pkg::*
// Notes: Pin levels are sampled on ref_clk_in; no register bus exists
package its_pkg;

    // Byte framing on the serial link
    localparam int unsigned ITS_DATA_BITS = 8;
    localparam logic [2:0] ITS_LAST_BIT = 3'h7;

    // Synchroniser depth for pins arriving from the bus
    localparam int unsigned ITS_SYNC_STAGES = 2;

    // Transmit buffer in front of the shift register
    localparam int unsigned ITS_TX_DEPTH = 2;

    // Reset values
    localparam logic ITS_CKP_RST = 1'h1;
    localparam logic ITS_FLAG_RST = 1'h0;
    localparam logic [7:0] ITS_BYTE_RST = 8'h00;
    localparam logic ITS_PIN_IDLE = 1'h1;

    // Transfer states, Gray coded along idle, ack, hold, shift, master ack
    typedef enum logic [2:0] {
        ITS_ST_IDLE  = 3'h0,
        ITS_ST_ACK   = 3'h1,
        ITS_ST_HOLD  = 3'h3,
        ITS_ST_SHIFT = 3'h2,
        ITS_ST_MACK  = 3'h6
    } its_state_t;

endpackage : its_pkg

// ==== its_sync.sv ====
// Purpose: Two-flop synchroniser for the bus pins
// Assumes: Inputs are asynchronous to ref_clk_in
// Notes: Only the last stage may be read by other logic
`timescale 1ns/10ps
module its_sync
    import its_pkg::*;
#(
    parameter int unsigned WIDTH = 2
)
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Pins and synchronised levels
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic meta_q;
            always_ff @(posedge ref_clk_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                begin
                    meta_q <= ITS_PIN_IDLE;
                    level_out[gi] <= ITS_PIN_IDLE;
                end
                else
                begin
                    meta_q <= pin_in[gi];
                    level_out[gi] <= meta_q;
                end
            end
        end
    endgenerate

endmodule : its_sync

// ==== its_fifo2.sv ====
// Purpose: Small transmit buffer with valid and ready on both sides
// Assumes: One clock; DEPTH is a power of two
// Notes: in_ready_out is registered so the top can pass it straight out
`timescale 1ns/10ps
module its_fifo2
    import its_pkg::*;
#(
    parameter int unsigned WIDTH = ITS_DATA_BITS,
    parameter int unsigned DEPTH = ITS_TX_DEPTH
)
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Filling side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Draining side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_valid_out = (count_q != '0);
    assign out_data_out = mem_q[rd_ptr_q];

    always_ff @(posedge ref_clk_in)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            in_ready_out <= 1'h1;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop)
            begin
                count_q <= count_q + 1'b1;
                in_ready_out <= (count_q != (AW+1)'(DEPTH - 1));
            end
            else if (pop && !push)
            begin
                count_q <= count_q - 1'b1;
                in_ready_out <= 1'h1;
            end
        end
    end

endmodule : its_fifo2

// ==== its_core.sv ====
// Purpose: Slave-transmit half of a two-wire serial port with clock stretching
// Assumes: Address matching and reception live outside and signal through pulses
// Notes: SCL and SDA are open drain; outputs are held low, enables drive them
// Operation
// RULE1: Read match sets direction, buffers address, acks
// RULE2: After read ack, clear release bit, hold SCL
// RULE3: Written data loads shifter; release bit frees SCL
// RULE4: Shift eight bits out on SCL falling edges
// RULE5: Latch master acknowledge on ninth rising edge
// RULE6: Not-acknowledge ends transfer, return to idle
// RULE7: Acknowledge from master stretches clock again
// RULE8: Interrupt flag set on ninth falling edge
// RULE9: Collision with detect enabled flags, goes idle
// RULE10: Start sets start flag, interrupt if enabled
// RULE11: Reading buffered address clears buffer-full flag
// RULE12: After not-acknowledge, no hold, flag still set
// RULE13: Drive SCL low only once already low
// RULE14: Hold SCL until release bit set
// RULE15: Stretch enable stretches after every acknowledge; its clear of the release bit on rx_ack_end_in does not hold SCL in idle
// RULE16: Buffer-full never affects stretching on reads
// RULE17: Update-address stretches without clearing release bit
// RULE18: Address hold clears release bit after eighth edge
// RULE19: Data hold clears release bit after eighth edge
// RULE20: Master starts, reads, acks or nacks, stops
// RULE21: Master waits while slave holds SCL low
`timescale 1ns/10ps
module its_core
    import its_pkg::*;
#(
    parameter int unsigned TX_DEPTH = ITS_TX_DEPTH
)
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Address match and receive half
    input wire logic addr_match_in,
    input wire logic addr_rw_in,
    input wire logic [7:0] addr_byte_in,
    input wire logic rx_data_end_in,
    input wire logic rx_ack_end_in,
    input wire logic ua_set_in,
    input wire logic slave_addr_wr_in,
    // Software data path
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_data_in,
    output logic tx_ready_out,
    input wire logic buf_rd_in,
    output logic [7:0] data_buffer_out,
    // Software control
    input wire logic clock_release_set_in,
    input wire logic serial_irq_clr_in,
    input wire logic collision_irq_clr_in,
    input wire logic stretch_enable_in,
    input wire logic slave_collision_detect_enable_in,
    input wire logic start_irq_enable_in,
    input wire logic address_hold_enable_in,
    input wire logic data_hold_enable_in,
    // Status
    output logic buffer_full_flag_out,
    output logic read_write_flag_out,
    output logic start_flag_out,
    output logic master_ack_flag_out,
    output logic serial_irq_flag_out,
    output logic collision_irq_flag_out,
    output logic clock_release_bit_out,
    output logic update_address_flag_out
);

    its_state_t st_q;
    logic scl_s;
    logic sda_s;
    logic scl_d_q;
    logic sda_d_q;
    logic scl_fall;
    logic scl_rise;
    logic start_det;
    logic stop_det;
    logic [7:0] sr_q;
    logic [2:0] bit_q;
    logic loaded_q;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic fifo_pop;
    logic hold_need;
    logic hw_ckp_clr;
    logic ninth_fall;
    logic collide;

    its_sync #(.WIDTH(2)) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in({scl_in, sda_in}),
        .level_out({scl_s, sda_s})
    );

    // A stall by the shifter backs up into software through tx_ready_out
    its_fifo2 #(.WIDTH(ITS_DATA_BITS), .DEPTH(TX_DEPTH)) u_txbuf (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(tx_valid_in),
        .in_data_in(tx_data_in),
        .in_ready_out(tx_ready_out),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data),
        .out_ready_in(fifo_pop)
    );

    assign scl_fall = scl_d_q && !scl_s;
    assign scl_rise = !scl_d_q && scl_s;
    assign start_det = scl_s && scl_d_q && sda_d_q && !sda_s;
    assign stop_det = scl_s && scl_d_q && !sda_d_q && sda_s;
    assign ninth_fall = scl_fall && (st_q == ITS_ST_ACK || st_q == ITS_ST_MACK);
    assign collide = (st_q == ITS_ST_SHIFT) && scl_rise && !sda_oe_out && !sda_s;
    assign fifo_pop = (st_q == ITS_ST_HOLD) && fifo_valid && !loaded_q;
    assign hold_need = !clock_release_bit_out || update_address_flag_out;

    // Every hardware reason to clear the release bit; the update-address flag also holds SCL, without clearing it
    always_comb
    begin
        hw_ckp_clr = 1'b0;
        if (st_q == ITS_ST_ACK && scl_fall)
            hw_ckp_clr = 1'b1; // RULE2 RULE15 RULE16
        if (st_q == ITS_ST_MACK && scl_fall && !master_ack_flag_out)
            hw_ckp_clr = 1'b1; // RULE7
        if (addr_match_in && address_hold_enable_in)
            hw_ckp_clr = 1'b1; // RULE18
        if (rx_data_end_in && data_hold_enable_in)
            hw_ckp_clr = 1'b1; // RULE19
        if (rx_ack_end_in && stretch_enable_in)
            hw_ckp_clr = 1'b1; // RULE15
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            scl_d_q <= ITS_PIN_IDLE;
            sda_d_q <= ITS_PIN_IDLE;
            scl_out <= 1'h0;
            sda_out <= 1'h0;
        end
        else
        begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    // Software setting the release bit wins over a hardware clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            clock_release_bit_out <= ITS_CKP_RST;
        else if (clock_release_set_in)
            clock_release_bit_out <= 1'h1; // RULE3
        else if (hw_ckp_clr)
            clock_release_bit_out <= 1'h0;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            update_address_flag_out <= ITS_FLAG_RST;
        else if (ua_set_in)
            update_address_flag_out <= 1'h1; // RULE17
        else if (slave_addr_wr_in)
            update_address_flag_out <= 1'h0; // RULE17
    end

    // Never pull SCL down first; only join a low that another device made
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            scl_oe_out <= 1'h0;
        else if (!hold_need || st_q == ITS_ST_IDLE && !update_address_flag_out)
            scl_oe_out <= 1'h0; // RULE14 RULE12
        else if (!scl_s)
            scl_oe_out <= 1'h1; // RULE13
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= ITS_ST_IDLE;
            sda_oe_out <= 1'h0;
            sr_q <= ITS_BYTE_RST;
            bit_q <= '0;
            loaded_q <= 1'h0;
        end
        else if (start_det || stop_det || collide && slave_collision_detect_enable_in)
        begin
            st_q <= ITS_ST_IDLE; // RULE9
            sda_oe_out <= 1'h0;
            loaded_q <= 1'h0;
        end
        else
        begin
            unique case (st_q)
                ITS_ST_IDLE:
                begin
                    if (addr_match_in && addr_rw_in)
                    begin
                        st_q <= ITS_ST_ACK;
                        sda_oe_out <= 1'h1; // RULE1
                    end
                end
                ITS_ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        st_q <= ITS_ST_HOLD;
                        sda_oe_out <= 1'h0;
                    end
                end
                ITS_ST_HOLD:
                begin
                    if (fifo_pop)
                    begin
                        sr_q <= fifo_data; // RULE3
                        loaded_q <= 1'h1;
                    end
                    else if (clock_release_bit_out && !update_address_flag_out)
                    begin
                        st_q <= ITS_ST_SHIFT;
                        sda_oe_out <= !sr_q[7]; // RULE4
                        bit_q <= '0;
                        loaded_q <= 1'h0;
                    end
                end
                ITS_ST_SHIFT:
                begin
                    if (scl_fall)
                    begin
                        sr_q <= {sr_q[6:0], 1'b0};
                        bit_q <= bit_q + 1'b1;
                        if (bit_q == ITS_LAST_BIT)
                        begin
                            st_q <= ITS_ST_MACK;
                            sda_oe_out <= 1'h0;
                        end
                        else
                            sda_oe_out <= !sr_q[6]; // RULE4
                    end
                end
                ITS_ST_MACK:
                begin
                    if (scl_fall)
                        st_q <= master_ack_flag_out ? ITS_ST_IDLE : ITS_ST_HOLD; // RULE6 RULE7
                end
                default:
                    st_q <= ITS_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            master_ack_flag_out <= ITS_FLAG_RST;
        else if (st_q == ITS_ST_MACK && scl_rise)
            master_ack_flag_out <= sda_s; // RULE5
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            data_buffer_out <= ITS_BYTE_RST;
            buffer_full_flag_out <= ITS_FLAG_RST;
            read_write_flag_out <= ITS_FLAG_RST;
        end
        else if (addr_match_in && addr_rw_in && st_q == ITS_ST_IDLE)
        begin
            data_buffer_out <= addr_byte_in; // RULE1
            buffer_full_flag_out <= 1'h1;
            read_write_flag_out <= 1'h1;
        end
        else
        begin
            if (buf_rd_in)
                buffer_full_flag_out <= 1'h0; // RULE11
            if (stop_det)
                read_write_flag_out <= 1'h0;
        end
    end

    // Hardware sets win over software clears in the same cycle
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            serial_irq_flag_out <= ITS_FLAG_RST;
        else if (ninth_fall || start_det && start_irq_enable_in)
            serial_irq_flag_out <= 1'h1; // RULE8 RULE10 RULE12
        else if (serial_irq_clr_in)
            serial_irq_flag_out <= 1'h0;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            collision_irq_flag_out <= ITS_FLAG_RST;
        else if (collide && slave_collision_detect_enable_in)
            collision_irq_flag_out <= 1'h1; // RULE9
        else if (collision_irq_clr_in)
            collision_irq_flag_out <= 1'h0;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            start_flag_out <= ITS_FLAG_RST;
        else if (start_det)
            start_flag_out <= 1'h1; // RULE10
        else if (stop_det)
            start_flag_out <= 1'h0;
    end

    sequence s_ninth_fall_ack;
        st_q == ITS_ST_ACK && scl_fall && !start_det && !stop_det;
    endsequence

    sequence s_nack_end;
        st_q == ITS_ST_MACK && scl_fall && master_ack_flag_out && !start_det && !stop_det;
    endsequence

    chk_ack_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE1
        st_q == ITS_ST_ACK |-> sda_oe_out && read_write_flag_out)
        else $error("ack not driven on read match");

    chk_ckp_after_ack: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE2
        s_ninth_fall_ack ##0 !clock_release_set_in |=>
        !clock_release_bit_out && st_q == ITS_ST_HOLD)
        else $error("release bit not cleared after read ack");

    chk_hold_joins_low: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE13
        $rose(scl_oe_out) |-> $past(!scl_s) && $past(hold_need))
        else $error("SCL pulled low before seen low");

    chk_hold_release: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE14
        clock_release_bit_out && !update_address_flag_out |=> !scl_oe_out)
        else $error("SCL held after release");

    chk_ack_latch: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE5
        st_q == ITS_ST_MACK && scl_rise |=> master_ack_flag_out == $past(sda_s))
        else $error("master ack not latched");

    chk_nack_idle: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE6
        s_nack_end |=> st_q == ITS_ST_IDLE && serial_irq_flag_out ##1 !scl_oe_out)
        else $error("nack did not end transfer");

    chk_irq_ninth: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE8
        ninth_fall |=> serial_irq_flag_out)
        else $error("interrupt flag missed on ninth edge");

    chk_collision: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE9
        collide && slave_collision_detect_enable_in |=>
        collision_irq_flag_out && st_q == ITS_ST_IDLE && !sda_oe_out)
        else $error("collision not handled");

    chk_start_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE10
        start_det |=> start_flag_out && (serial_irq_flag_out || !$past(start_irq_enable_in)))
        else $error("start not flagged");

    chk_bf_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE11
        buf_rd_in && !addr_match_in |=> !buffer_full_flag_out)
        else $error("buffer full not cleared on read");

    chk_shift_edge: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE4
        st_q == ITS_ST_SHIFT && !scl_fall && !start_det && !stop_det && !collide
        |=> $stable(sda_oe_out))
        else $error("SDA changed off a falling edge");

endmodule : its_core

// ==== its_master_model.sv ====
// Purpose: Bus master model that clocks bytes out of the slave
// Assumes: Both lines have pull-ups; SCL half period is 62.5 ns
// Notes: SCL stands high between frames; slave stretching is honoured
`timescale 1ns/10ps
module its_master_model
(
    // Slave pin enables
    input wire logic scl_oe_in,
    input wire logic sda_oe_in,
    // Resolved line levels
    output logic scl_out,
    output logic sda_out,
    // Received bytes and health
    output logic byte_valid_out,
    output logic [7:0] byte_out,
    output logic stuck_out
);
    logic scl_low = 1'h0;
    logic sda_low = 1'h0;

    // Pull-ups win whenever nobody pulls a line down
    assign scl_out = !(scl_low || scl_oe_in);
    assign sda_out = !(sda_low || sda_oe_in);

    initial
    begin
        byte_valid_out = 1'h0;
        byte_out = 8'h00;
        stuck_out = 1'h0;
    end

    task automatic start_cond();
        sda_low = 1'h1;
        #62.5;
        scl_low = 1'h1;
        #62.5;
    endtask : start_cond

    task automatic stop_cond();
        sda_low = 1'h1;
        #62.5;
        scl_low = 1'h0;
        #62.5;
        sda_low = 1'h0;
        #62.5;
    endtask : stop_cond

    // Released SCL may stay low while the slave stretches
    task automatic clk_bit(input logic tx, output logic rx);
        sda_low = !tx;
        #62.5;
        scl_low = 1'h0;
        for (int i = 0; i < 3000 && scl_out !== 1'h1; i++)
            #10;
        if (scl_out !== 1'h1)
            stuck_out = 1'h1;
        #31;
        rx = sda_out;
        #31.5;
        scl_low = 1'h1;
    endtask : clk_bit

    // A jammed byte holds SDA low to force a collision
    task automatic get_byte(input logic nack, input logic jam);
        logic [7:0] b;
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(!jam, r);
            b[i] = r;
        end
        if (!jam)
        begin
            byte_out = b;
            byte_valid_out = 1'h1;
            #1;
            byte_valid_out = 1'h0;
        end
        clk_bit(nack, r);
    endtask : get_byte
endmodule : its_master_model

// ==== its_core_tb.sv ====
// Purpose: Self-checking bench for the slave-transmit block
// Assumes: Master model resolves both open-drain lines
// Notes: Expected bytes are queued as software loads them
`timescale 1ns/10ps
module its_core_tb;
    import its_pkg::*;
    logic ref_clk_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic [8:0] pls = 9'h000;
    logic rw_bit = 1'h1;
    logic hold_en = 1'h0;
    logic scl_lvl, sda_lvl;
    logic [7:0] addr_byte_in = 8'h00;
    logic tx_valid_in = 1'h0;
    logic [7:0] tx_data_in = 8'h00;
    logic coll_en = 1'h0;
    logic sie = 1'h0;
    logic scl_w, sda_w, scl_oe, sda_oe, bvalid, stuck, tx_ready, bf, rw;
    logic sflag, mack, sirq, cirq, rel, ua;
    logic [7:0] bbyte, dbuf;
    logic [7:0] exp_q[$];
    int err_total = 0;
    int tests_run = 0;

    always #5 ref_clk_in = !ref_clk_in;

    its_core dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .scl_in(scl_w),
        .scl_out(scl_lvl), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(sda_lvl),
        .sda_oe_out(sda_oe),
        .addr_match_in(pls[0]), .addr_rw_in(rw_bit), .addr_byte_in(addr_byte_in),
        .rx_data_end_in(pls[7]), .rx_ack_end_in(pls[8]), .ua_set_in(pls[5]),
        .slave_addr_wr_in(pls[6]), .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in),
        .tx_ready_out(tx_ready), .buf_rd_in(pls[1]), .data_buffer_out(dbuf),
        .clock_release_set_in(pls[2]), .serial_irq_clr_in(pls[3]),
        .collision_irq_clr_in(pls[4]), .stretch_enable_in(hold_en),
        .slave_collision_detect_enable_in(coll_en), .start_irq_enable_in(sie),
        .address_hold_enable_in(hold_en), .data_hold_enable_in(hold_en),
        .buffer_full_flag_out(bf), .read_write_flag_out(rw), .start_flag_out(sflag),
        .master_ack_flag_out(mack), .serial_irq_flag_out(sirq),
        .collision_irq_flag_out(cirq), .clock_release_bit_out(rel),
        .update_address_flag_out(ua));

    its_master_model m (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .scl_out(scl_w),
        .sda_out(sda_w), .byte_valid_out(bvalid), .byte_out(bbyte), .stuck_out(stuck));

    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk8

    task automatic chk1(input logic e, input logic g);
        chk8({7'h00, e}, {7'h00, g});
    endtask : chk1

    task automatic wrap_up();
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // Software strobes last one clock and are seen settled afterwards
    task automatic pulse(input int i);
        @(posedge ref_clk_in);
        pls[i] <= 1'h1;
        @(posedge ref_clk_in);
        pls <= 9'h000;
        @(negedge ref_clk_in);
    endtask : pulse

    task automatic wait_rel0();
        for (int i = 0; i < 5000 && rel !== 1'h0; i++)
            @(negedge ref_clk_in);
        repeat (2) @(negedge ref_clk_in);
    endtask : wait_rel0

    task automatic push(input logic [7:0] b);
        @(posedge ref_clk_in);
        tx_valid_in <= 1'h1;
        tx_data_in <= b;
        exp_q.push_back(b);
        @(negedge ref_clk_in);
        while (tx_ready !== 1'h1)
            @(negedge ref_clk_in);
        @(posedge ref_clk_in);
        tx_valid_in <= 1'h0;
        @(negedge ref_clk_in);
    endtask : push

    task automatic xfer(input int n, input logic jam, input logic s);
        logic [7:0] a;
        logic r;
        a = 8'($urandom) | 8'h01;
        @(posedge ref_clk_in);
        addr_byte_in <= a;
        sie <= s;
        coll_en <= jam;
        fork
            begin
                m.start_cond();
                repeat (5) @(negedge ref_clk_in);
                chk1(1'h1, sflag);
                chk1(s, sirq);
                pulse(3);
                for (int i = 7; i >= 0; i--)
                    m.clk_bit(a[i], r);
                repeat (4) @(negedge ref_clk_in);
                pulse(0);
                m.clk_bit(1'h1, r);
                chk1(1'h0, r);
                for (int k = 0; k < n; k++)
                    m.get_byte(k == n - 1, jam);
                m.stop_cond();
            end
            begin
                wait_rel0();
                chk1(1'h1, rw);
                chk8(a, dbuf);
                chk1(1'h1, bf);
                chk1(1'h1, sirq);
                chk1(1'h1, scl_oe);
                pulse(1);
                chk1(1'h0, bf);
                pulse(3);
                for (int k = 0; k < n; k++)
                    push(8'($urandom) | {jam, 7'h00});
                if (n == 3)
                    chk1(1'h0, tx_ready);
                for (int k = 0; k < n; k++)
                begin
                    if (k > 0)
                    begin
                        wait_rel0();
                        chk1(1'h1, scl_oe);
                        chk1(1'h1, sirq);
                        pulse(3);
                    end
                    pulse(2);
                end
            end
        join
        repeat (4) @(negedge ref_clk_in);
        chk1(1'h0, scl_oe);
        chk1(1'h0, sflag);
        if (!jam)
        begin
            chk1(1'h1, mack);
            chk1(1'h1, rel);
            chk1(1'h1, sirq);
        end
        else
        begin
            chk1(1'h1, cirq);
            pulse(4);
            chk1(1'h0, cirq);
            exp_q.delete();
        end
        pulse(3);
    endtask : xfer

    always @(posedge bvalid)
        chk8(exp_q.size() > 0 ? exp_q.pop_front() : ~bbyte, bbyte);

    initial
    begin
        void'($urandom(89));
        repeat (5) @(posedge ref_clk_in);
        rst_b_in <= 1'h1;
        @(negedge ref_clk_in);
        chk1(ITS_CKP_RST, rel);
        chk1(1'h1, tx_ready);
        chk8(8'h00, {bf, rw, sflag, mack, sirq, cirq, ua, scl_oe | sda_oe});
        chk1(1'h0, scl_lvl | sda_lvl);
        // A write match must not answer, but the hold enables still clear the release bit
        @(posedge ref_clk_in);
        rw_bit <= 1'h0;
        hold_en <= 1'h1;
        pulse(0);
        chk1(1'h0, rw);
        chk1(1'h0, sda_oe);
        chk1(1'h0, rel);
        pulse(2);
        pulse(7);
        chk1(1'h0, rel);
        pulse(2);
        pulse(8);
        chk1(1'h0, rel);
        pulse(2);
        chk1(1'h1, rel);
        chk1(1'h0, scl_oe);
        @(posedge ref_clk_in);
        rw_bit <= 1'h1;
        hold_en <= 1'h0;
        xfer(3, 1'h0, 1'h1);
        xfer(1, 1'h1, 1'h0);
        pulse(5);
        chk1(1'h1, ua);
        chk1(1'h1, rel);
        pulse(6);
        chk1(1'h0, ua);
        chk1(1'h0, stuck);
        wrap_up();
    end

    // Both transfers finish well inside this span
    initial
    begin
        #300000;
        err_total++;
        wrap_up();
    end
endmodule : its_core_tb
